// ==== logic/tmr16_counter.sv ====
// 16-bit timer / event counter / window counter with AXI4-Lite register access
`timescale 1ns/100ps
// Summary of operation
// - three modes: internal timer, external edge event counter, gated window counter
// - timer on fc source in slow dual-clock mode times oscillator warm-up from slow to normal
// - timer mode counts selected internal clock, compared for equality with compare value
// - timer match raises match pulse, clears counter, counting resumes from zero
// - fc source in slow dual-clock mode matches upper five compare bits only
// - event mode counts each rising edge of the external count input
// - event match is checked and signalled on the external input falling edge
// - after an event match the count continues on later rising edges
// - window mode counts internal clock only while the gate pin is high
// - window match raises match pulse and clears the counter
// - window mode does not count in slow or sleep power modes
// - entering stop power mode clears the run bit automatically
module tmr16_counter
	import tmr16_pkg::*;
#(
	parameter int FC_SLOW_E = tmr16_pkg::FC_TAP_E3,
	parameter int FC_MID_E  = tmr16_pkg::FC_TAP_E2
) (
	input  wire logic                        CORE_CLK_I,
	input  wire logic                        RST_I,
	input  wire logic                        EXT_COUNT_I,
	input  wire logic                        LOW_CLK_I,
	output logic                             MATCH_IRQ_O,
	input  wire logic [tmr16_pkg::ADDR_W-1:0] AWADDR_I,
	input  wire logic                        AWVALID_I,
	output logic                             AWREADY_O,
	input  wire logic [31:0]                 WDATA_I,
	input  wire logic [3:0]                  WSTRB_I,
	input  wire logic                        WVALID_I,
	output logic                             WREADY_O,
	output logic [1:0]                       BRESP_O,
	output logic                             BVALID_O,
	input  wire logic                        BREADY_I,
	input  wire logic [tmr16_pkg::ADDR_W-1:0] ARADDR_I,
	input  wire logic                        ARVALID_I,
	output logic                             ARREADY_O,
	output logic [31:0]                      RDATA_O,
	output logic [1:0]                       RRESP_O,
	output logic                             RVALID_O,
	input  wire logic                        RREADY_I
);
	import tmr16_pkg::*;

	typedef struct packed {
		logic [1:0]        pin_sync;
		logic              pin_d;
		logic [1:0]        fs_sync;
		logic              fs_d;
		logic [5:0]        ctrl;
		logic [7:0]        cmp_lo_stage;
		logic [15:0]       cmp;
		logic [3:0]        pwr;
		logic [15:0]       count;
		logic              irq;
		logic              aw_full;
		logic [ADDR_W-1:0] awaddr;
		logic              w_full;
		logic [31:0]       wdata;
		logic              wlane0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_s;

	state_s s;
	state_s next_s;

	logic [3:0]  fc_tap;
	logic [1:0]  fs_tap;
	logic        fs_tick;
	logic        pin_rise;
	logic        pin_fall;
	logic        gate;
	logic        slow;
	logic        warm;
	logic        src_tick;
	logic        ev_mode;
	logic        win_mode;
	logic        tim_mode;
	logic        inc;
	logic        hit;
	logic [15:0] cnt_inc;
	logic [2:0]  cksel;
	logic [2:0]  pmode;

	tmr16_prescaler #(
		.FC_E0 (FC_TAP_E0),
		.FC_E1 (FC_TAP_E1),
		.FC_E2 (FC_MID_E),
		.FC_E3 (FC_SLOW_E),
		.FS_E0 (FS_TAP_E0),
		.FS_E1 (FS_TAP_E1)
	) u_prescaler (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.fs_tick_i (fs_tick),
		.fc_tap_o  (fc_tap),
		.fs_tap_o  (fs_tap)
	);

	// edges seen only after the second synchroniser stage
	assign fs_tick  = s.fs_sync[1] & ~s.fs_d;
	assign pin_rise = s.pin_sync[1] & ~s.pin_d;
	assign pin_fall = ~s.pin_sync[1] & s.pin_d;
	assign gate     = s.pin_sync[1];
	assign cksel    = s.ctrl[CKSEL_LSB+2:CKSEL_LSB];
	assign pmode    = s.pwr[2:0];
	assign slow     = (pmode == PWR_SLOW_SINGLE_CLOCK_MODE) | (pmode == PWR_SLOW_DUAL_CLOCK_MODE) | (pmode == PWR_SLEEP);
	assign warm     = (pmode == PWR_SLOW_DUAL_CLOCK_MODE) & (cksel == CK_FC);
	assign ev_mode  = ~s.ctrl[MODE_BIT] & (cksel == CK_EXT);
	assign win_mode = s.ctrl[MODE_BIT];
	assign tim_mode = ~s.ctrl[MODE_BIT] & (cksel != CK_EXT);
	assign cnt_inc  = s.count + 16'h0001;

	// source select; fs taps replace the CK_FC_D23 and CK_FC_D13 fc taps in slow modes or with the tap select set
	always_comb begin
		unique case (cksel)
			CK_FC_D23: src_tick = (slow | s.pwr[TAPSEL_BIT]) ? fs_tap[1] : fc_tap[3];
			CK_FC_D13: src_tick = (slow | s.pwr[TAPSEL_BIT]) ? fs_tap[0] : fc_tap[2];
			CK_FC_D8:  src_tick = ~slow & fc_tap[1];
			CK_FC_D3:  src_tick = ~slow & fc_tap[0];
			CK_FC:     src_tick = warm;
			CK_FS:     src_tick = ~slow & fs_tick;
			default:   src_tick = 1'b0;
		endcase
	end

	assign inc = (tim_mode & src_tick) | (win_mode & src_tick & gate & ~slow);
	// warm-up compares the top five bits so the low byte write may be skipped
	assign hit = warm ? (cnt_inc[15:11] == s.cmp[15:11]) : (cnt_inc == s.cmp);

	// all next-state logic: synchronisers, counter, register file, bus handshakes
	always_comb begin
		next_s          = s;
		next_s.pin_sync = {s.pin_sync[0], EXT_COUNT_I};
		next_s.pin_d    = s.pin_sync[1];
		next_s.fs_sync  = {s.fs_sync[0], LOW_CLK_I};
		next_s.fs_d     = s.fs_sync[1];
		next_s.irq      = 1'b0;

		// counter core
		if (!s.ctrl[RUN_BIT]) begin
			next_s.count = 16'h0000;
		end else if (ev_mode) begin
			if (pin_rise) begin
				next_s.count = cnt_inc;
			end else if (pin_fall && s.count == s.cmp) begin
				next_s.count = 16'h0000;
				next_s.irq   = 1'b1;
			end
		end else if (inc) begin
			if (hit) begin
				next_s.count = 16'h0000;
				next_s.irq   = 1'b1;
			end else begin
				next_s.count = cnt_inc;
			end
		end

		// write channels accepted independently, in either order
		if (AWVALID_I && s.awready) begin
			next_s.aw_full = 1'b1;
			next_s.awaddr  = AWADDR_I;
		end
		if (WVALID_I && s.wready) begin
			next_s.w_full = 1'b1;
			next_s.wdata  = WDATA_I;
			next_s.wlane0 = WSTRB_I[0];
		end
		if (s.bvalid && BREADY_I) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_full && s.w_full && !s.bvalid) begin
			next_s.aw_full = 1'b0;
			next_s.w_full  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = RESP_OKAY;
			// all fields live in byte lane 0; other lanes are ignored
			unique case (s.awaddr)
				CTRL_OFS: if (s.wlane0) next_s.ctrl = s.wdata[5:0];
				CMP_LO_OFS: if (s.wlane0) next_s.cmp_lo_stage = s.wdata[7:0];
				// high byte commits with the staged low byte
				CMP_HI_OFS: if (s.wlane0) next_s.cmp = {s.wdata[7:0], s.cmp_lo_stage};
				POWER_OFS: if (s.wlane0) next_s.pwr = s.wdata[3:0];
				COUNT_OFS: next_s.bresp = RESP_OKAY;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		// stop mode drops the run bit and keeps it down until stop is left
		if (next_s.pwr[2:0] == PWR_STOP) begin
			next_s.ctrl[RUN_BIT] = 1'b0;
		end
		next_s.awready = ~next_s.aw_full;
		next_s.wready  = ~next_s.w_full;

		// read channel, one outstanding read
		if (s.rvalid && RREADY_I) begin
			next_s.rvalid = 1'b0;
		end
		if (ARVALID_I && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			unique case (ARADDR_I)
				CTRL_OFS:   next_s.rdata = {26'h0, s.ctrl};
				CMP_LO_OFS: next_s.rdata = {24'h000000, s.cmp_lo_stage};
				CMP_HI_OFS: next_s.rdata = {24'h000000, s.cmp[15:8]};
				COUNT_OFS:  next_s.rdata = {16'h0000, s.count};
				POWER_OFS:  next_s.rdata = {28'h0000000, s.pwr};
				default: begin
					next_s.rdata = 32'h00000000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = ~next_s.rvalid;
	end

	// single state register
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			s              <= '0;
			s.ctrl         <= CTRL_RST;
			s.cmp          <= CMP_RST;
			s.cmp_lo_stage <= CMP_RST[7:0];
			s.pwr          <= PWR_RST;
		end else begin
			s <= next_s;
		end
	end

	assign MATCH_IRQ_O = s.irq;
	assign AWREADY_O   = s.awready;
	assign WREADY_O    = s.wready;
	assign BVALID_O    = s.bvalid;
	assign BRESP_O     = s.bresp;
	assign ARREADY_O   = s.arready;
	assign RVALID_O    = s.rvalid;
	assign RDATA_O     = s.rdata;
	assign RRESP_O     = s.rresp;

	// checks on the counter behaviour
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_run_clears: assert property (!s.ctrl[RUN_BIT] |=> s.count == 16'h0000 && !s.irq)
		else $error("counter not held clear while stopped");
	a_timer_incr: assert property (s.ctrl[RUN_BIT] && tim_mode && inc && !hit
		|=> s.count == $past(s.count) + 16'h0001 && !s.irq)
		else $error("timer did not count on source tick");
	a_timer_match: assert property (s.ctrl[RUN_BIT] && tim_mode && inc && hit |=> s.irq && s.count == 16'h0000)
		else $error("timer match did not clear and signal");
	a_warm_mask: assert property (s.ctrl[RUN_BIT] && tim_mode && warm && inc
		&& cnt_inc[15:11] == s.cmp[15:11] |=> s.irq)
		else $error("warm-up match ignored upper bits");
	a_event_rise: assert property (s.ctrl[RUN_BIT] && ev_mode && pin_rise
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("event rise not counted");
	a_event_fall: assert property (s.ctrl[RUN_BIT] && ev_mode && pin_fall && s.count == s.cmp
		|=> s.irq && s.count == 16'h0000)
		else $error("event match not signalled on falling edge");
	a_event_quiet: assert property (ev_mode && !pin_fall |=> !s.irq)
		else $error("event match outside falling edge");
	a_win_gate: assert property (s.ctrl[RUN_BIT] && win_mode && !gate |=> $stable(s.count) && !s.irq)
		else $error("window counted with gate low");
	a_win_slow: assert property (s.ctrl[RUN_BIT] && win_mode && slow |=> $stable(s.count))
		else $error("window counted in slow mode");
	a_stop_run: assert property (next_s.pwr[2:0] == PWR_STOP |=> !s.ctrl[RUN_BIT])
		else $error("run bit survived stop mode");
	a_win_match: assert property (s.ctrl[RUN_BIT] && win_mode && inc && hit |=> s.irq ##1 !s.irq)
		else $error("window match pulse wrong");
	// the counter only moves on its selected tick; a fall without match leaves it alone
	a_win_count: assert property (s.ctrl[RUN_BIT] && win_mode && gate && !slow && src_tick && !hit
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("window did not count with gate high");
	a_event_miss: assert property (s.ctrl[RUN_BIT] && ev_mode && pin_fall && s.count != s.cmp
		|=> $stable(s.count) && !s.irq)
		else $error("event fall without match changed the count");
	a_warm_tick: assert property (s.ctrl[RUN_BIT] && tim_mode && warm && !hit
		|=> s.count == $past(s.count) + 16'h0001)
		else $error("warm-up source did not tick every cycle");
	// bus answers must stand until the master takes them
	a_bresp_hold: assert property (s.bvalid && !BREADY_I |=> s.bvalid && $stable(s.bresp))
		else $error("write response dropped before taken");
	a_rdata_hold: assert property (s.rvalid && !RREADY_I |=> s.rvalid && $stable(s.rdata))
		else $error("read data dropped before taken");

	c_timer_match: cover property (tim_mode && !warm && s.irq);
	c_warm_match: cover property (warm && s.irq);
	c_event_match: cover property (ev_mode && s.irq);
	c_window_match: cover property (win_mode && s.irq);
	c_bus_slverr: cover property (s.bvalid && s.bresp == RESP_SLVERR);
endmodule

// ==== logic/tmr16_pkg.sv ====
// constants, register map and field layout for the 16-bit timer/event/window counter
package tmr16_pkg;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
	localparam logic [ADDR_W-1:0] CMP_LO_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CMP_HI_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h0C;
	localparam logic [ADDR_W-1:0] POWER_OFS  = 8'h10;

	// counter_control_reg fields
	localparam int RUN_BIT   = 5;
	localparam int CKSEL_LSB = 2;
	localparam int MODE_BIT  = 0;

	// power register fields: [2:0] operating power mode, [3] prescaler_tap_select
	localparam int TAPSEL_BIT = 3;
	localparam logic [2:0] PWR_NORMAL1 = 3'h0;
	localparam logic [2:0] PWR_NORMAL_DUAL_CLOCK_MODE = 3'h1;
	localparam logic [2:0] PWR_SLOW_SINGLE_CLOCK_MODE   = 3'h2;
	localparam logic [2:0] PWR_SLOW_DUAL_CLOCK_MODE   = 3'h3;
	localparam logic [2:0] PWR_IDLE    = 3'h4;
	localparam logic [2:0] PWR_SLEEP   = 3'h5;
	localparam logic [2:0] PWR_STOP    = 3'h6;

	// source_clock_select codes
	localparam logic [2:0] CK_FC_D23 = 3'h0;
	localparam logic [2:0] CK_FC_D13 = 3'h1;
	localparam logic [2:0] CK_FC_D8  = 3'h2;
	localparam logic [2:0] CK_FC_D3  = 3'h3;
	localparam logic [2:0] CK_FC     = 3'h4;
	localparam logic [2:0] CK_FS     = 3'h5;
	localparam logic [2:0] CK_EXT    = 3'h7;

	// values after reset
	localparam logic [5:0]  CTRL_RST = 6'h00;
	localparam logic [15:0] CMP_RST  = 16'hFFFF;
	localparam logic [3:0]  PWR_RST  = 4'h1;

	// prescaler tap exponents (divide by 2^n)
	localparam int FC_TAP_E0 = 3;
	localparam int FC_TAP_E1 = 8;
	localparam int FC_TAP_E2 = 13;
	localparam int FC_TAP_E3 = 23;
	localparam int FS_TAP_E0 = 5;
	localparam int FS_TAP_E1 = 15;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/tmr16_prescaler.sv ====
// free-running prescaler producing one-cycle tap enables from the core clock and the fs tick
`timescale 1ns/100ps
module tmr16_prescaler #(
	parameter int FC_E0 = 3,
	parameter int FC_E1 = 8,
	parameter int FC_E2 = 13,
	parameter int FC_E3 = 23,
	parameter int FS_E0 = 5,
	parameter int FS_E1 = 15
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       fs_tick_i,
	output logic      [3:0] fc_tap_o,
	output logic      [1:0] fs_tap_o
);
	localparam int FC_E[4] = '{FC_E0, FC_E1, FC_E2, FC_E3};
	localparam int FS_E[2] = '{FS_E0, FS_E1};

	// counter widths cover the longest tap, whatever order the exponents come in
	localparam int FC_WA = (FC_E0 > FC_E1) ? FC_E0 : FC_E1;
	localparam int FC_WB = (FC_E2 > FC_E3) ? FC_E2 : FC_E3;
	localparam int FC_W  = (FC_WA > FC_WB) ? FC_WA : FC_WB;
	localparam int FS_W  = (FS_E0 > FS_E1) ? FS_E0 : FS_E1;

	logic [FC_W-1:0] fc_cnt;
	logic [FS_W-1:0] fs_cnt;
	wire  [3:0]      fc_hit;
	wire  [1:0]      fs_hit;

	// both chains free-run so the taps keep a fixed phase whatever the counter does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fc_cnt <= '0;
			fs_cnt <= '0;
		end else begin
			fc_cnt <= fc_cnt + 1'b1;
			if (fs_tick_i) begin
				fs_cnt <= fs_cnt + 1'b1;
			end
		end
	end

	// a tap fires when all bits below its exponent are ones
	for (genvar g = 0; g < 4; g++) begin : g_fc
		assign fc_hit[g] = &fc_cnt[FC_E[g]-1:0];
	end

	for (genvar g = 0; g < 2; g++) begin : g_fs
		assign fs_hit[g] = fs_tick_i & (&fs_cnt[FS_E[g]-1:0]);
	end

	// taps registered in one process so each output has a single driver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fc_tap_o <= 4'h0;
			fs_tap_o <= 2'h0;
		end else begin
			fc_tap_o <= fc_hit;
			fs_tap_o <= fs_hit;
		end
	end
endmodule

// ==== sim/ext_src.sv ====
// external count and gate pin source facing the counter
`timescale 1ns/100ps
module ext_src (
	input  wire logic clk_i,
	output logic      pin_o
);
	// pin idles low between pulse trains
	initial begin
		pin_o = 1'b0;
	end

	// pulses held at the shortest legal width, 8 core cycles each phase
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk_i);
			pin_o <= 1'b1;
			repeat (8) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (7) @(posedge clk_i);
		end
	endtask

	// gate level changes are held for many ticks by the caller
	task automatic gate(input logic v);
		@(posedge clk_i);
		pin_o <= v;
	endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the 16-bit timer/event/window counter
`timescale 1ns/100ps
module testbench;
	import tmr16_pkg::*;
	logic        clk, rst, low_clk, irq, ext;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          errors, n_compared, cycles, c;

	// short tap exponents keep the slow sources quick in simulation
	tmr16_counter #(.FC_SLOW_E(6), .FC_MID_E(5)) tmr16_counter_inst (
		.CORE_CLK_I(clk), .RST_I(rst), .EXT_COUNT_I(ext), .LOW_CLK_I(low_clk),
		.MATCH_IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
		.ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rvalid), .RREADY_I(rready));
	ext_src ext_src_inst (.clk_i(clk), .pin_o(ext));

	// core clock 100 MHz and an unrelated slow clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		low_clk = 1'b0;
		forever #163 low_clk = ~low_clk;
	end

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors = errors + 1;
			give_verdict();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// axi4-lite write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic setcmp(input logic [15:0] v);
		wr(CMP_LO_OFS, {24'h0, v[7:0]});
		wr(CMP_HI_OFS, {24'h0, v[15:8]});
	endtask

	// cycles until the next match pulse, lim when none comes
	task automatic wait_irq(input int lim);
		c = 0;
		do begin
			@(posedge clk);
			c = c + 1;
		end while (irq !== 1'b1 && c < lim);
	endtask

	task automatic t_reset_map;
		rd(CTRL_OFS);
		chk("ctrl", d, 32'h0);
		rd(POWER_OFS);
		chk("power", d, 32'h1);
		rd(8'h14);
		chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h14, 32'h0);
		chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		// lane 0 strobe low: the control write must be dropped
		wstrb <= 4'hE;
		wr(CTRL_OFS, 32'h2C);
		wstrb <= 4'hF;
		rd(CTRL_OFS);
		chk("lane 0 strobe off", d, 32'h0);
	endtask

	// fc/2^3 source, compare 4: one match every 32 core cycles
	task automatic t_timer;
		setcmp(16'h0004);
		wr(CTRL_OFS, 32'h0C);
		wr(CTRL_OFS, 32'h2C);
		wait_irq(200);
		wait_irq(200);
		chk("timer period", c, 32'd32);
		wr(CTRL_OFS, 32'h0C);
		wait_irq(100);
		chk("no match when stopped", c, 32'd100);
		rd(COUNT_OFS);
		chk("count stopped", d, 32'h0);
	endtask

	task automatic t_event;
		setcmp(16'h0003);
		wr(CTRL_OFS, 32'h1C);
		wr(CTRL_OFS, 32'h3C);
		ext_src_inst.pulse(2);
		repeat (6) @(posedge clk);
		rd(COUNT_OFS);
		chk("event count", d, 32'h2);
		// the pulse is a single cycle, so watch while the pin is driven:
		// launch edge, eight high cycles, three cycles of sync and edge stage, one to see it
		fork
			ext_src_inst.pulse(1);
			wait_irq(40);
		join
		chk("match after fall", c, 32'd13);
		rd(COUNT_OFS);
		chk("event cleared", d, 32'h0);
		ext_src_inst.pulse(1);
		repeat (6) @(posedge clk);
		rd(COUNT_OFS);
		chk("event resumes", d, 32'h1);
		wr(CTRL_OFS, 32'h1C);
	endtask

	task automatic t_window;
		logic [31:0] held;
		setcmp(16'h0010);
		wr(CTRL_OFS, 32'h0D);
		wr(CTRL_OFS, 32'h2D);
		repeat (100) @(posedge clk);
		rd(COUNT_OFS);
		chk("gate low", d, 32'h0);
		ext_src_inst.gate(1'b1);
		repeat (80) @(posedge clk);
		rd(COUNT_OFS);
		chk("gate high", d >= 8 && d <= 12, 1'b1);
		// gate held high: sixteen fc/2^3 ticks between matches
		wait_irq(300);
		wait_irq(300);
		chk("window period", c, 32'd128);
		wr(POWER_OFS, {29'h0, PWR_SLOW_DUAL_CLOCK_MODE});
		rd(COUNT_OFS);
		held = d;
		repeat (80) @(posedge clk);
		rd(COUNT_OFS);
		chk("window held in slow", d, held);
		ext_src_inst.gate(1'b0);
		wr(POWER_OFS, {29'h0, PWR_STOP});
		rd(CTRL_OFS);
		chk("stop clears run", d, 32'h0D);
		rd(COUNT_OFS);
		chk("count cleared", d, 32'h0);
		wr(POWER_OFS, {29'h0, PWR_NORMAL_DUAL_CLOCK_MODE});
	endtask

	// only the high byte written: bits 15:11 = 2 gives 4096 cycles
	task automatic t_warmup;
		wr(CTRL_OFS, 32'h10);
		wr(POWER_OFS, {29'h0, PWR_SLOW_DUAL_CLOCK_MODE});
		wr(CMP_HI_OFS, 32'h10);
		wr(CTRL_OFS, 32'h30);
		wait_irq(5000);
		wait_irq(5000);
		chk("warm-up period", c, 32'd4096);
		wr(CTRL_OFS, 32'h10);
		wr(POWER_OFS, {29'h0, PWR_NORMAL_DUAL_CLOCK_MODE});
	endtask

	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence: reset, then one task per behaviour
	initial begin
		errors = 0;
		n_compared = 0;
		cycles = 0;
		rst = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset_map();
		t_timer();
		t_event();
		t_window();
		t_warmup();
		give_verdict();
	end
endmodule
